// ==== verilog/dgp_pkg.sv ====
// Constants shared by the digitizer general-purpose pin block.
// Assumes one data clock; pin inputs arrive synchronous to it.
//
// Notes on behaviour
// RULE1 - Trigger input keeps sampling the event connector even while it drives.
// RULE2 - Pin levels are always captured, whatever the direction.
// RULE3 - A two-way pin driver stays off until direction selects output.
// RULE4 - A driving pin shows the last level written by the write command.
// RULE5 - Reading a driving pin returns the level being driven.
// RULE6 - Twelve single-ended pins, each with own direction and level.
// RULE7 - Differential lines: two inputs, two clock inputs, four outputs.
// RULE8 - Differential pin directions are fixed; no command changes them.
// RULE9 - Custom firmware reads and writes pin values through user registers.
// RULE10 - Event and alignment connectors reach firmware with the same structure.
// RULE11 - Controller selects source, sets output, arms, then writes level one.
// RULE12 - Connector pins route automatically to whichever function is active; code drives fp_pin_oe from fp_dir_r, set by command or firmware.
// RULE13 - Every pin input passes a two-stage synchronizer before use.
package dgp_pkg;

   // ***********************************************************
   // Pin counts and encodings
   // ***********************************************************
   localparam int unsigned SE_PINS    = 12;
   localparam int unsigned DIFF_IN    = 2;
   localparam int unsigned DIFF_CLKIN = 2;
   localparam int unsigned DIFF_OUT   = 4;
   localparam int unsigned FP_PINS    = 2;   // Event input and alignment

   // User register index map for firmware access
   localparam logic [3:0] UREG_SE_DIR   = 4'h0;
   localparam logic [3:0] UREG_SE_LVL   = 4'h1;
   localparam logic [3:0] UREG_SE_IN    = 4'h2;
   localparam logic [3:0] UREG_FP_DIR   = 4'h3;
   localparam logic [3:0] UREG_FP_LVL   = 4'h4;
   localparam logic [3:0] UREG_FP_IN    = 4'h5;
   localparam logic [3:0] UREG_DIFF_OUT = 4'h6;
   localparam logic [3:0] UREG_DIFF_IN  = 4'h7;

   // Reset values
   localparam logic [11:0] SE_DIR_RST  = 12'h000;
   localparam logic [11:0] SE_LVL_RST  = 12'h000;
   localparam logic [1:0]  FP_DIR_RST  = 2'h0;
   localparam logic [1:0]  FP_LVL_RST  = 2'h0;
   localparam logic [3:0]  DOUT_RST    = 4'h0;

endpackage

// ==== verilog/dgp_port.sv ====
// Pin logic for front-panel event/alignment connectors and the
// dedicated connector. Software commands and firmware register
// accesses share the same direction and level state.
`timescale 1ns/1ps

module dgp_port (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   // Software commands, one-cycle strobes
   input  wire logic        set_pin_direction_cmd,
   input  wire logic        write_pin_level_cmd,
   input  wire logic        read_pin_level_cmd,
   input  wire logic [3:0]  cmd_bank,
   input  wire logic [11:0] cmd_mask,
   input  wire logic [11:0] cmd_value,
   output logic             read_valid,
   output logic [11:0]      read_data,
   // Firmware user register access
   input  wire logic        user_reg_write_cmd,
   input  wire logic        user_reg_read_cmd,
   input  wire logic [3:0]  ureg_index,
   input  wire logic [11:0] ureg_wdata,
   output logic             ureg_rvalid,
   output logic [11:0]      ureg_rdata,
   // Front-panel event input and alignment connectors
   input  wire logic [1:0]  fp_pin_i,
   output logic [1:0]       fp_pin_o,
   output logic [1:0]       fp_pin_oe,
   output logic             event_input_level,
   output logic             align_input_level,
   // Dedicated connector single-ended pins
   input  wire logic [11:0] se_pin_i,
   output logic [11:0]      se_pin_o,
   output logic [11:0]      se_pin_oe,
   // Dedicated connector differential lines, fixed direction
   input  wire logic [1:0]  diff_in_pos,
   input  wire logic [1:0]  diff_clk_in_pos,
   output logic [3:0]       diff_out_pos
);

   // ***********************************************************
   // Input synchronisers
   // ***********************************************************
   logic [11:0] se_s1_r, se_s2_r;
   logic [1:0]  fp_s1_r, fp_s2_r;
   logic [3:0]  df_s1_r, df_s2_r;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         se_s1_r <= 12'h000;
         se_s2_r <= 12'h000;
         fp_s1_r <= 2'h0;
         fp_s2_r <= 2'h0;
         df_s1_r <= 4'h0;
         df_s2_r <= 4'h0;
      end else begin
         // Sampled regardless of direction [RULE2] [RULE13]
         se_s1_r <= se_pin_i;
         se_s2_r <= se_s1_r;
         fp_s1_r <= fp_pin_i;   // [RULE1]
         fp_s2_r <= fp_s1_r;
         df_s1_r <= {diff_clk_in_pos, diff_in_pos};   // [RULE8]
         df_s2_r <= df_s1_r;
      end
   end

   // ***********************************************************
   // Command decode
   // ***********************************************************
   // Bank codes reuse the user register indices so both paths agree
   wire sw_se_dir = set_pin_direction_cmd && cmd_bank == dgp_pkg::UREG_SE_DIR;
   wire sw_fp_dir = set_pin_direction_cmd && cmd_bank == dgp_pkg::UREG_FP_DIR;
   wire sw_se_lvl = write_pin_level_cmd && cmd_bank == dgp_pkg::UREG_SE_LVL;
   wire sw_fp_lvl = write_pin_level_cmd && cmd_bank == dgp_pkg::UREG_FP_LVL;
   wire sw_dout   = write_pin_level_cmd
                    && cmd_bank == dgp_pkg::UREG_DIFF_OUT;

   wire fw_se_dir = user_reg_write_cmd && ureg_index == dgp_pkg::UREG_SE_DIR;
   wire fw_se_lvl = user_reg_write_cmd && ureg_index == dgp_pkg::UREG_SE_LVL;
   wire fw_fp_dir = user_reg_write_cmd && ureg_index == dgp_pkg::UREG_FP_DIR;
   wire fw_fp_lvl = user_reg_write_cmd && ureg_index == dgp_pkg::UREG_FP_LVL;
   wire fw_dout   = user_reg_write_cmd
                    && ureg_index == dgp_pkg::UREG_DIFF_OUT;

   // Masked update; firmware write takes the whole field
   function automatic logic [11:0] merge(input logic [11:0] cur,
                                         input logic [11:0] msk,
                                         input logic [11:0] val);
      merge = (cur & ~msk) | (val & msk);
   endfunction

   logic [11:0] se_dir_r, se_lvl_r;
   logic [1:0]  fp_dir_r, fp_lvl_r;
   logic [3:0]  dout_r;

   // Firmware wins if both land in the same cycle
   wire [11:0] se_dir_nxt = fw_se_dir ? ureg_wdata :
                            sw_se_dir ? merge(se_dir_r, cmd_mask, cmd_value)
                                      : se_dir_r;
   wire [11:0] se_lvl_nxt = fw_se_lvl ? ureg_wdata :
                            sw_se_lvl ? merge(se_lvl_r, cmd_mask, cmd_value)
                                      : se_lvl_r;
   wire [11:0] fp_dm = merge({10'h000, fp_dir_r}, cmd_mask, cmd_value);
   wire [11:0] fp_lm = merge({10'h000, fp_lvl_r}, cmd_mask, cmd_value);
   wire [11:0] do_m  = merge({8'h00, dout_r}, cmd_mask, cmd_value);
   wire [1:0]  fp_dir_nxt = fw_fp_dir ? ureg_wdata[1:0] :
                            sw_fp_dir ? fp_dm[1:0] : fp_dir_r;
   wire [1:0]  fp_lvl_nxt = fw_fp_lvl ? ureg_wdata[1:0] :
                            sw_fp_lvl ? fp_lm[1:0] : fp_lvl_r;
   wire [3:0]  dout_nxt   = fw_dout ? ureg_wdata[3:0] :
                            sw_dout ? do_m[3:0] : dout_r;

   // ***********************************************************
   // Direction, level and pin drive
   // ***********************************************************
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         se_dir_r <= dgp_pkg::SE_DIR_RST;   // Drivers off [RULE3]
         se_lvl_r <= dgp_pkg::SE_LVL_RST;
         fp_dir_r <= dgp_pkg::FP_DIR_RST;
         fp_lvl_r <= dgp_pkg::FP_LVL_RST;
         dout_r   <= dgp_pkg::DOUT_RST;
      end else begin
         se_dir_r <= se_dir_nxt;   // Per-pin control [RULE6] [RULE9]
         se_lvl_r <= se_lvl_nxt;   // [RULE4]
         fp_dir_r <= fp_dir_nxt;   // [RULE10]
         fp_lvl_r <= fp_lvl_nxt;
         dout_r   <= dout_nxt;     // Outputs only [RULE7] [RULE8]
      end
   end

   // Pin outputs registered one stage after the state
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         se_pin_o     <= 12'h000;
         se_pin_oe    <= 12'h000;
         fp_pin_o     <= 2'h0;
         fp_pin_oe    <= 2'h0;
         diff_out_pos <= 4'h0;
      end else begin
         se_pin_oe    <= se_dir_r;              // [RULE3]
         se_pin_o     <= se_lvl_r & se_dir_r;   // [RULE4]
         fp_pin_oe    <= fp_dir_r;              // [RULE12]
         fp_pin_o     <= fp_lvl_r & fp_dir_r;
         diff_out_pos <= dout_r;
      end
   end

   // ***********************************************************
   // Read path
   // ***********************************************************
   // Driving pins report the driven level, avoiding pad round-trip lag
   wire [11:0] se_rd = (se_dir_r & se_lvl_r) | (~se_dir_r & se_s2_r);
   wire [1:0]  fp_rd = (fp_dir_r & fp_lvl_r) | (~fp_dir_r & fp_s2_r);

   function automatic logic [11:0] rd_mux(input logic [3:0] idx,
                                          input logic [11:0] sdir,
                                          input logic [11:0] slvl,
                                          input logic [11:0] srd,
                                          input logic [1:0]  fdir,
                                          input logic [1:0]  flvl,
                                          input logic [1:0]  frd,
                                          input logic [3:0]  dov,
                                          input logic [3:0]  div);
      if (idx == dgp_pkg::UREG_SE_DIR)        rd_mux = sdir;
      else if (idx == dgp_pkg::UREG_SE_LVL)   rd_mux = slvl;
      else if (idx == dgp_pkg::UREG_SE_IN)    rd_mux = srd;
      else if (idx == dgp_pkg::UREG_FP_DIR)   rd_mux = {10'h000, fdir};
      else if (idx == dgp_pkg::UREG_FP_LVL)   rd_mux = {10'h000, flvl};
      else if (idx == dgp_pkg::UREG_FP_IN)    rd_mux = {10'h000, frd};
      else if (idx == dgp_pkg::UREG_DIFF_OUT) rd_mux = {8'h00, dov};
      else if (idx == dgp_pkg::UREG_DIFF_IN)  rd_mux = {8'h00, div};
      else                                    rd_mux = 12'h000;
   endfunction

   wire [11:0] sw_rd = rd_mux(cmd_bank, se_dir_r, se_lvl_r, se_rd,
                              fp_dir_r, fp_lvl_r, fp_rd, dout_r, df_s2_r);
   wire [11:0] fw_rd = rd_mux(ureg_index, se_dir_r, se_lvl_r, se_rd,
                              fp_dir_r, fp_lvl_r, fp_rd, dout_r, df_s2_r);

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         read_valid        <= 1'b0;
         read_data         <= 12'h000;
         ureg_rvalid       <= 1'b0;
         ureg_rdata        <= 12'h000;
         event_input_level <= 1'b0;
         align_input_level <= 1'b0;
      end else begin
         read_valid  <= read_pin_level_cmd;
         if (read_pin_level_cmd) begin
            read_data <= sw_rd;   // [RULE2] [RULE5]
         end
         ureg_rvalid <= user_reg_read_cmd;
         if (user_reg_read_cmd) begin
            ureg_rdata <= fw_rd;   // [RULE9]
         end
         // Pad level, never the internal level [RULE1] [RULE11]
         event_input_level <= fp_s2_r[0];
         align_input_level <= fp_s2_r[1];
      end
   end

   // ***********************************************************
   // Checks
   // ***********************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   oe_follows_dir_a: assert property ( // [RULE3]
      se_pin_oe == $past(se_dir_r)) else $error("oe not from direction");
   drive_level_a: assert property ( // [RULE4]
      se_pin_oe[0] |-> se_pin_o[0] == $past(se_lvl_r[0]))
      else $error("driven level wrong");
   write_lands_a: assert property ( // [RULE4]
      fw_se_lvl |=> ##1 se_pin_o == ($past(ureg_wdata, 2) & se_pin_oe))
      else $error("firmware level not driven");
   read_driven_a: assert property ( // [RULE5]
      read_pin_level_cmd && cmd_bank == dgp_pkg::UREG_SE_IN
      && se_dir_r[0] |=> read_data[0] == $past(se_lvl_r[0]))
      else $error("read not driven level");
   read_input_a: assert property ( // [RULE2]
      read_pin_level_cmd && cmd_bank == dgp_pkg::UREG_SE_IN
      && !se_dir_r[0] |=> read_data[0] == $past(se_pin_i[0], 3))
      else $error("read not pin level");
   event_input_connector_listens_a: assert property ( // [RULE1]
      event_input_level == $past(fp_pin_i[0], 3))
      else $error("event input not sampled");
   diff_fixed_a: assert property ( // [RULE8]
      set_pin_direction_cmd && !sw_dout && !fw_dout
      |=> ##1 diff_out_pos == $past(dout_r, 2))
      else $error("diff output disturbed");
   fp_oe_a: assert property ( // [RULE12]
      fw_fp_dir |=> ##1 fp_pin_oe == $past(ureg_wdata[1:0], 2))
      else $error("fp direction not applied");
   ureg_read_a: assert property ( // [RULE9]
      user_reg_read_cmd |=> ureg_rvalid) else $error("no ureg answer");

   out_cov_c:  cover property (sw_se_dir ##[1:8] sw_se_lvl);
   fw_cov_c:   cover property (fw_fp_lvl ##2 fp_pin_o[0]);
   event_input_connector_cov_c: cover property (fp_pin_oe[0] && event_input_level);

endmodule // dgp_port

// ==== verif/dgp_far_end.sv ====
// External equipment wired to the pins of the general-purpose port.
// Assumes the bench sets the far-side levels; pad level is resolved here.
`timescale 1ns/1ps

module dgp_far_end (
   // Design side
   input  wire logic [11:0] se_pin_o,
   input  wire logic [11:0] se_pin_oe,
   input  wire logic [1:0]  fp_pin_o,
   input  wire logic [1:0]  fp_pin_oe,
   // Levels the equipment drives when the pin is free
   input  wire logic [11:0] ext_se,
   input  wire logic [1:0]  ext_fp,
   input  wire logic [3:0]  ext_diff,
   // Pad levels seen by the design
   output logic [11:0]      se_pin_i,
   output logic [1:0]       fp_pin_i,
   output logic [1:0]       diff_in_pos,
   output logic [1:0]       diff_clk_in_pos
);
   // Equipment yields the wire wherever the design drives it
   assign se_pin_i = (se_pin_oe & se_pin_o) | (~se_pin_oe & ext_se);
   assign fp_pin_i = (fp_pin_oe & fp_pin_o) | (~fp_pin_oe & ext_fp);
   assign diff_in_pos     = ext_diff[1:0];
   assign diff_clk_in_pos = ext_diff[3:2];
endmodule // dgp_far_end

// ==== verif/testbench.sv ====
// Self-checking bench for the general-purpose pin block.
// Assumes the far-end model resolves pads; waits follow the fixed latencies.
`timescale 1ns/1ps

module testbench;
   logic        clk_sys, rstn, sdir_c, swr_c, srd_c, uwr_c, urd_c;
   logic [3:0]  cmd_bank, ureg_index, ext_diff;
   logic [11:0] cmd_mask, cmd_value, ureg_wdata, ext_se;
   logic [1:0]  ext_fp;
   wire logic   read_valid, ureg_rvalid, event_input_level, align_input_level;
   wire logic [11:0] read_data, ureg_rdata, se_pin_i, se_pin_o, se_pin_oe;
   wire logic [1:0]  fp_pin_i, fp_pin_o, fp_pin_oe, diff_in_pos, diff_clk_in_pos;
   wire logic [3:0]  diff_out_pos;
   int n_mismatch, tests_run, seed, i, r;
   logic [11:0] se_dir, se_lvl, fp_dir, fp_lvl, dout, m;
   logic [3:0]  b;

   dgp_port dgp_port_i (.clk_sys(clk_sys), .rstn(rstn),
      .set_pin_direction_cmd(sdir_c), .write_pin_level_cmd(swr_c),
      .read_pin_level_cmd(srd_c), .cmd_bank(cmd_bank), .cmd_mask(cmd_mask),
      .cmd_value(cmd_value), .read_valid(read_valid), .read_data(read_data),
      .user_reg_write_cmd(uwr_c), .user_reg_read_cmd(urd_c),
      .ureg_index(ureg_index), .ureg_wdata(ureg_wdata),
      .ureg_rvalid(ureg_rvalid), .ureg_rdata(ureg_rdata),
      .fp_pin_i(fp_pin_i), .fp_pin_o(fp_pin_o), .fp_pin_oe(fp_pin_oe),
      .event_input_level(event_input_level),
      .align_input_level(align_input_level), .se_pin_i(se_pin_i),
      .se_pin_o(se_pin_o), .se_pin_oe(se_pin_oe), .diff_in_pos(diff_in_pos),
      .diff_clk_in_pos(diff_clk_in_pos), .diff_out_pos(diff_out_pos));
   dgp_far_end dgp_far_end_i (.se_pin_o(se_pin_o), .se_pin_oe(se_pin_oe),
      .fp_pin_o(fp_pin_o), .fp_pin_oe(fp_pin_oe), .ext_se(ext_se),
      .ext_fp(ext_fp), .ext_diff(ext_diff), .se_pin_i(se_pin_i),
      .fp_pin_i(fp_pin_i), .diff_in_pos(diff_in_pos),
      .diff_clk_in_pos(diff_clk_in_pos));

   // ***********************************************************
   // Model and checks
   // ***********************************************************
   function automatic logic [11:0] exp_rb(input logic [3:0] k);
      case (k)
         4'h0: return se_dir;
         4'h1: return se_lvl;
         4'h2: return (se_dir & se_lvl) | (~se_dir & ext_se);
         4'h3: return fp_dir & 12'h003;
         4'h4: return fp_lvl & 12'h003;
         4'h5: return ((fp_dir & fp_lvl) | (~fp_dir & ext_fp)) & 12'h003;
         4'h6: return dout & 12'h00f;
         4'h7: return {8'h00, ext_diff};
         default: return 12'h000;
      endcase
   endfunction

   task automatic apply(input logic [3:0] k, input logic [11:0] mk, v);
      case (k)
         4'h0: se_dir = (se_dir & ~mk) | (v & mk);
         4'h1: se_lvl = (se_lvl & ~mk) | (v & mk);
         4'h3: fp_dir = (fp_dir & ~mk) | (v & mk);
         4'h4: fp_lvl = (fp_lvl & ~mk) | (v & mk);
         4'h6: dout = (dout & ~mk) | (v & mk);
         default: ;
      endcase
   endtask

   task automatic chk_val(input logic [11:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic sw_cmd(input int k, input logic [3:0] bk,
                         input logic [11:0] mk, v);
      cmd_bank = bk; cmd_mask = mk; cmd_value = v;
      sdir_c = (k == 0); swr_c = (k == 1); srd_c = (k == 2);
      @(posedge clk_sys); #1;
      sdir_c = 0; swr_c = 0; srd_c = 0;
      // Direction only lands on banks 0 and 3, levels on banks 1, 4 and 6
      if (k != 2 && ((k == 0) == (bk == 4'h0 || bk == 4'h3)))
         apply(bk, mk, v);
   endtask

   task automatic fw_cmd(input logic wr, input logic [3:0] k,
                         input logic [11:0] v);
      ureg_index = k; ureg_wdata = v; uwr_c = wr; urd_c = !wr;
      @(posedge clk_sys); #1;
      uwr_c = 0; urd_c = 0;
      if (wr) apply(k, 12'hfff, v);
   endtask

   // Both read paths, every index including unmapped ones
   task automatic read_all;
      for (int k = 0; k < 16; k++) begin
         sw_cmd(2, 4'(k), 12'h000, 12'h000);
         chk_val({11'h000, read_valid}, 12'h001);
         chk_val(read_data, exp_rb(4'(k)));
         fw_cmd(1'b0, 4'(k), 12'h000);
         chk_val({11'h000, ureg_rvalid}, 12'h001);
         chk_val(ureg_rdata, exp_rb(4'(k)));
      end
   endtask

   task automatic chk_pins;
      repeat (4) @(posedge clk_sys);
      #1;
      chk_val(se_pin_oe, se_dir);
      chk_val(se_pin_o, se_dir & se_lvl);
      chk_val({10'h000, fp_pin_oe}, fp_dir & 12'h003);
      chk_val({10'h000, fp_pin_o}, fp_dir & fp_lvl & 12'h003);
      chk_val({8'h00, diff_out_pos}, dout & 12'h00f);
      chk_val({10'h000, align_input_level, event_input_level},
              exp_rb(4'h5));
   endtask

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ***********************************************************
   // Clock, watchdog and sequence
   // ***********************************************************
   initial begin
      clk_sys = 0;
      forever #4 clk_sys = ~clk_sys;
   end

   initial begin
      repeat (40000) @(posedge clk_sys);
      n_mismatch++;
      end_of_test();
   end

   initial begin
      {rstn, sdir_c, swr_c, srd_c, uwr_c, urd_c} = 6'h00;
      {cmd_bank, ureg_index, ext_diff, ext_fp} = 14'h0000;
      {cmd_mask, cmd_value, ureg_wdata, ext_se} = 48'h0;
      {se_dir, se_lvl, fp_dir, fp_lvl, dout} = 60'h0;
      n_mismatch = 0; tests_run = 0; seed = 32'h52a1;
      repeat (10) @(posedge clk_sys);
      #1 rstn = 1;
      chk_pins();
      read_all();
      // Level written while still an input must not drive
      ext_se = 12'ha5c;
      sw_cmd(1, 4'h1, 12'hfff, 12'h3c6);
      chk_pins();
      // Drive the event connector and trigger from its own output
      sw_cmd(0, 4'h3, 12'h001, 12'h001);
      sw_cmd(1, 4'h4, 12'h001, 12'h001);
      chk_pins();
      // Direction commands on the fixed differential banks do nothing
      sw_cmd(0, 4'h6, 12'hfff, 12'hfff);
      sw_cmd(0, 4'h7, 12'hfff, 12'hfff);
      chk_pins();
      for (i = 0; i < 40; i++) begin
         r = $random(seed);
         ext_se = 12'($random(seed));
         ext_fp = r[6:5];
         ext_diff = r[10:7];
         m = 12'($random(seed));
         b = r[2] ? 4'h0 : 4'h1;
         if (r[3]) b = b + 4'h3;
         if (r[4] && !r[2]) b = 4'h6;
         if (r[11])
            fw_cmd(1'b1, r[12] ? 4'h9 : b, r[31:20]);
         else
            sw_cmd(r[2] ? 0 : 1, b, m, r[31:20]);
         chk_pins();
         if (i % 8 == 0) read_all();
      end
      end_of_test();
   end
endmodule // testbench
